// file: verilog/vrxcr_map.svh
`ifndef VRXCR_MAP_SVH
`define VRXCR_MAP_SVH
// Register offsets on the internal register access port.
`define VRXCR_DITHER_TIMING_OFS   8'h29
`define VRXCR_COLOR_BAL_OFS       8'h2A
`define VRXCR_AUDIO_SER_OFS       8'h2B
`define VRXCR_PCLK_TEST_OFS       8'h2E
`define VRXCR_RX_PORT_OFS         8'h34
// Reset values.
`define VRXCR_DITHER_TIMING_RST   8'h00
`define VRXCR_COLOR_BAL_RST       8'h00
`define VRXCR_AUDIO_SER_RST       8'h00
`define VRXCR_PCLK_TEST_RST       8'h00
`define VRXCR_RX_PORT_RST         8'h01
// Writable masks; other bits are reserved, save the audio error flags and clear bit.
`define VRXCR_COLOR_BAL_WMASK     8'hF0
`define VRXCR_AUDIO_SER_WMASK     8'h01
`define VRXCR_PCLK_TEST_WMASK     8'h80
`define VRXCR_RX_PORT_WMASK       8'h7B
// Field positions.
`define VRXCR_TIMING_MODE_BIT     7
`define VRXCR_LINE_POL_BIT        6
`define VRXCR_FRAME_POL_BIT       5
`define VRXCR_VALID_POL_BIT       4
`define VRXCR_DITHER2_BIT         3
`define VRXCR_DITHER1_BIT         2
`define VRXCR_PRECISE2_OFF_BIT    1
`define VRXCR_PRECISE1_OFF_BIT    0
`define VRXCR_BALANCE_ON_BIT      5
`define VRXCR_REFRESH_ON_BIT      4
`define VRXCR_OVERRUN_BIT         3
`define VRXCR_UNDERRUN_BIT        2
`define VRXCR_ERR_CLEAR_BIT       1
`define VRXCR_RISING_EDGE_BIT     0
`define VRXCR_SELFTEST_CLK_BIT    7
`define VRXCR_LOCK_MODE_BIT       6
`define VRXCR_RAW_RETURN_BIT      5
`define VRXCR_SECOND_PORT_BIT     1
`define VRXCR_FIRST_PORT_BIT      0
`endif

// file: verilog/vrxcr_pkg.sv
package vrxcr_pkg;
  typedef logic [7:0] vrxcr_byte_t;
  typedef enum logic [1:0] {
    VRXCR_PAGE_CFG   = 2'h0,
    VRXCR_PAGE_RED   = 2'h1,
    VRXCR_PAGE_GREEN = 2'h2,
    VRXCR_PAGE_BLUE  = 2'h3
  } vrxcr_page_e;
  typedef enum logic [1:0] {
    VRXCR_IN_AUTO    = 2'h0,
    VRXCR_IN_DUAL    = 2'h1,
    VRXCR_IN_PRIMARY = 2'h2,
    VRXCR_IN_SECOND  = 2'h3
  } vrxcr_inmode_e;
endpackage

// file: verilog/vrxcr_sync_if.sv
`timescale 1ns/1ps
// Carries the synchronised pin levels from the input stage to the bank.
interface vrxcr_sync_if;
  logic video_off;
  logic linked;
  logic gp_pin;
  logic overrun_ev;
  logic underrun_ev;
  modport src (output video_off, output linked, output gp_pin,
               output overrun_ev, output underrun_ev);
  modport dst (input video_off, input linked, input gp_pin,
               input overrun_ev, input underrun_ev);
endinterface

// file: verilog/vrxcr_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous status pins.
module vrxcr_sync
  import vrxcr_pkg::*;
(
  // Clock and reset.
  input  wire logic    clk,
  input  wire logic    rst_n,
  // Raw pins.
  input  wire logic    video_off_pin,
  input  wire logic    linked_pin,
  input  wire logic    gp_pin_raw,
  input  wire logic    overrun_pin,
  input  wire logic    underrun_pin,
  // Synchronised side.
  vrxcr_sync_if.src    sy
);
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
  } vrxcr_sync_s;

  vrxcr_sync_s st_r;
  vrxcr_sync_s st_nxt;

  // First stage feeds only the second stage.
  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = {underrun_pin, overrun_pin, gp_pin_raw, linked_pin, video_off_pin};
    st_nxt.s2 = st_r.s1;
  end

  // Video-off resets high so lock stays low until the link says otherwise.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '{s1: 5'h01, s2: 5'h01};
    else
      st_r <= st_nxt;
  end

  assign sy.video_off   = st_r.s2[0];
  assign sy.linked      = st_r.s2[1];
  assign sy.gp_pin      = st_r.s2[2];
  assign sy.overrun_ev  = st_r.s2[3];
  assign sy.underrun_ev = st_r.s2[4];
endmodule

// file: verilog/vrxcr_regs.sv
`timescale 1ns/1ps
`include "vrxcr_map.svh"
module vrxcr_regs
  import vrxcr_pkg::*;
(
  // Clock and reset.
  input  wire logic                   CORE_CLK,
  input  wire logic                   RESETN,
  // Register access port.
  input  wire logic                   REG_WR,
  input  wire logic                   REG_RD,
  input  wire vrxcr_pkg::vrxcr_byte_t REG_ADDR,
  input  wire vrxcr_pkg::vrxcr_byte_t REG_WDATA,
  output logic [7:0]                  REG_RDATA,
  output logic                        REG_HIT,
  // Link and audio status pins.
  input  wire logic                   VIDEO_OFF_PIN,
  input  wire logic                   LINKED_PIN,
  input  wire logic                   GP_PIN_ZERO,
  input  wire logic                   AUDIO_OVERRUN,
  input  wire logic                   AUDIO_UNDERRUN,
  // Video timing and dither controls.
  output logic                        SYNC_FRAMING,
  output logic                        LINE_SYNC_POLARITY,
  output logic                        FRAME_SYNC_POLARITY,
  output logic                        VALID_PIXEL_POLARITY,
  output logic                        DITHER_STAGE2_ON,
  output logic                        DITHER_STAGE1_ON,
  output logic                        PRECISE_DITHER2_ON,
  output logic                        PRECISE_DITHER1_ON,
  // Colour balance controls.
  output vrxcr_pkg::vrxcr_page_e      PAGE_SEL,
  output logic                        BALANCE_ON,
  output logic                        TABLE_REFRESH_ON,
  // Audio and clock controls.
  output logic                        AUDIO_RISING_STROBE,
  output logic                        SELFTEST_CLOCK_SEL,
  // Receive port controls.
  output logic                        RX_LOCK,
  output logic                        RAW_AUX_RETURN_PATH,
  output logic                        RAW_AUX_DATA,
  output vrxcr_pkg::vrxcr_inmode_e    LINK_INPUT_CONFIG,
  output logic                        FIRST_PORT_WRITE,
  output logic                        SECOND_PORT_WRITE,
  output logic                        SECOND_PORT_READ
);
  import vrxcr_pkg::*;

  typedef struct packed {
    logic [7:0] dither;
    logic [7:0] balance;
    logic [7:0] audio;
    logic [7:0] pclk;
    logic [7:0] rxport;
    logic       overrun;
    logic       underrun;
    logic       lock;
    logic [7:0] rdata;
  } vrxcr_state_s;

  vrxcr_state_s st_r;
  vrxcr_state_s st_nxt;
  vrxcr_sync_if sy ();

  // Pins cross into the clock domain before anything reads them.
  vrxcr_sync u_sync (
    .clk           (CORE_CLK),
    .rst_n         (RESETN),
    .video_off_pin (VIDEO_OFF_PIN),
    .linked_pin    (LINKED_PIN),
    .gp_pin_raw    (GP_PIN_ZERO),
    .overrun_pin   (AUDIO_OVERRUN),
    .underrun_pin  (AUDIO_UNDERRUN),
    .sy            (sy.src)
  );

  // Address decode, used by both the write and read paths.
  function automatic logic [4:0] dec(input logic [7:0] a);
    dec = {a == `VRXCR_RX_PORT_OFS, a == `VRXCR_PCLK_TEST_OFS,
           a == `VRXCR_AUDIO_SER_OFS, a == `VRXCR_COLOR_BAL_OFS,
           a == `VRXCR_DITHER_TIMING_OFS};
  endfunction

  logic [4:0] sel;
  logic       clr_wr;
  assign sel    = dec(REG_ADDR);
  assign clr_wr = REG_WR && sel[2] && REG_WDATA[`VRXCR_ERR_CLEAR_BIT];

  // Register writes, sticky error flags, lock and read data.
  always_comb
  begin
    st_nxt = st_r;
    if (REG_WR && sel[0])
      st_nxt.dither = REG_WDATA;
    if (REG_WR && sel[1])
      st_nxt.balance = REG_WDATA & `VRXCR_COLOR_BAL_WMASK;
    if (REG_WR && sel[2])
      st_nxt.audio = REG_WDATA & `VRXCR_AUDIO_SER_WMASK;
    if (REG_WR && sel[3])
      st_nxt.pclk = REG_WDATA & `VRXCR_PCLK_TEST_WMASK;
    if (REG_WR && sel[4])
      st_nxt.rxport = REG_WDATA & `VRXCR_RX_PORT_WMASK;
    // A clear and a fresh event in one cycle: the event wins.
    if (clr_wr)
    begin
      st_nxt.overrun  = 1'b0;
      st_nxt.underrun = 1'b0;
    end
    if (sy.overrun_ev)
      st_nxt.overrun = 1'b1;
    if (sy.underrun_ev)
      st_nxt.underrun = 1'b1;
    // Lock follows video only unless lock mode allows a bare link.
    if (st_r.rxport[`VRXCR_LOCK_MODE_BIT])
      st_nxt.lock = sy.linked;
    else
      st_nxt.lock = sy.linked && !sy.video_off;
    // Read data is registered; unmapped offsets read zero.
    if (REG_RD)
    begin
      case (1'b1)
        sel[0]:  st_nxt.rdata = st_r.dither;
        sel[1]:  st_nxt.rdata = st_r.balance;
        sel[2]:  st_nxt.rdata = st_r.audio | {4'h0, st_r.overrun, st_r.underrun, 2'h0};
        sel[3]:  st_nxt.rdata = st_r.pclk;
        sel[4]:  st_nxt.rdata = st_r.rxport;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      st_r <= '{dither: `VRXCR_DITHER_TIMING_RST, balance: `VRXCR_COLOR_BAL_RST,
                audio: `VRXCR_AUDIO_SER_RST, pclk: `VRXCR_PCLK_TEST_RST,
                rxport: `VRXCR_RX_PORT_RST, overrun: 1'b0, underrun: 1'b0,
                lock: 1'b0, rdata: 8'h00};
    else
      st_r <= st_nxt;
  end

  assign REG_RDATA = st_r.rdata;
  assign REG_HIT   = |sel;

  // Decoded controls toward the datapath.
  assign SYNC_FRAMING         = st_r.dither[`VRXCR_TIMING_MODE_BIT];
  assign LINE_SYNC_POLARITY   = st_r.dither[`VRXCR_LINE_POL_BIT];
  assign FRAME_SYNC_POLARITY  = st_r.dither[`VRXCR_FRAME_POL_BIT];
  assign VALID_PIXEL_POLARITY = st_r.dither[`VRXCR_VALID_POL_BIT];
  assign DITHER_STAGE2_ON     = st_r.dither[`VRXCR_DITHER2_BIT];
  assign DITHER_STAGE1_ON     = st_r.dither[`VRXCR_DITHER1_BIT];
  assign PRECISE_DITHER2_ON   = !st_r.dither[`VRXCR_PRECISE2_OFF_BIT];
  assign PRECISE_DITHER1_ON   = !st_r.dither[`VRXCR_PRECISE1_OFF_BIT];
  assign PAGE_SEL             = vrxcr_page_e'(st_r.balance[7:6]);
  assign BALANCE_ON           = st_r.balance[`VRXCR_BALANCE_ON_BIT];
  assign TABLE_REFRESH_ON     = st_r.balance[`VRXCR_REFRESH_ON_BIT];
  assign AUDIO_RISING_STROBE  = st_r.audio[`VRXCR_RISING_EDGE_BIT];
  assign SELFTEST_CLOCK_SEL   = st_r.pclk[`VRXCR_SELFTEST_CLK_BIT];
  assign RX_LOCK              = st_r.lock;
  assign RAW_AUX_RETURN_PATH  = st_r.rxport[`VRXCR_RAW_RETURN_BIT];
  // Raw mode passes the synchronised pin straight through, no filter.
  assign RAW_AUX_DATA         = RAW_AUX_RETURN_PATH & sy.gp_pin;
  assign LINK_INPUT_CONFIG    = vrxcr_inmode_e'(st_r.rxport[4:3]);
  assign FIRST_PORT_WRITE     = st_r.rxport[`VRXCR_FIRST_PORT_BIT];
  assign SECOND_PORT_WRITE    = st_r.rxport[`VRXCR_SECOND_PORT_BIT];
  // Second port wins reads whenever its select is set.
  assign SECOND_PORT_READ     = st_r.rxport[`VRXCR_SECOND_PORT_BIT];

  chk_lock_needs_video: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !st_r.rxport[6] && sy.video_off |=> !RX_LOCK) else $error("lock with video off");
  chk_lock_bare_link: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    st_r.rxport[6] && sy.linked |=> RX_LOCK) else $error("lock missing on link");
  chk_overrun_sticky: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    sy.overrun_ev |=> st_r.overrun) else $error("overrun not recorded");
  chk_error_clear: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    clr_wr && !sy.overrun_ev && !sy.underrun_ev |=> !st_r.overrun && !st_r.underrun)
    else $error("error flags not cleared");
  chk_reserved_zero: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (st_r.balance[3:0] == 4'h0) && (st_r.pclk[6:0] == 7'h00) && !st_r.rxport[7]
    && !st_r.rxport[2]) else $error("reserved bit set");
  chk_precise_inverse: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    REG_WR && sel[0] |=> PRECISE_DITHER1_ON == !$past(REG_WDATA[0]))
    else $error("precise dither sense wrong");
  chk_test_clock: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    REG_WR && sel[3] |=> SELFTEST_CLOCK_SEL == $past(REG_WDATA[7]))
    else $error("test clock select wrong");
  chk_raw_return: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !RAW_AUX_RETURN_PATH |-> !RAW_AUX_DATA) else $error("raw path leaks");

  // A write taken at one decoded register.
  sequence seq_wr_hit(hit);
    REG_WR && hit;
  endsequence

  // A read taken at one decoded register or at an unmapped offset.
  sequence seq_rd_hit(hit);
    REG_RD && hit;
  endsequence

  // Link up with active video, both seen after the synchroniser.
  sequence seq_video_link;
    sy.linked && !sy.video_off;
  endsequence

  // Link up while the far end sends no video.
  sequence seq_bare_link;
    sy.linked && sy.video_off;
  endsequence

  // Framing mode follows bit 7 of the last timing write.
  chk_timing_mode: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_wr_hit(sel[0]) |=> SYNC_FRAMING == $past(REG_WDATA[7]))
    else $error("timing mode wrong");

  // The three polarity controls follow bits 6 to 4.
  chk_sync_polarity: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_wr_hit(sel[0]) |=> {LINE_SYNC_POLARITY, FRAME_SYNC_POLARITY,
    VALID_PIXEL_POLARITY} == $past(REG_WDATA[6:4])) else $error("sync polarity wrong");

  // Both dither stages follow their enable bits directly.
  chk_dither_stages: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_wr_hit(sel[0]) |=> {DITHER_STAGE2_ON, DITHER_STAGE1_ON} == $past(REG_WDATA[3:2]))
    else $error("dither stage enable wrong");

  // The second precise mode is off only when its bit is one.
  chk_precise_second: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_wr_hit(sel[0]) |=> PRECISE_DITHER2_ON == !$past(REG_WDATA[1]))
    else $error("second precise dither sense wrong");

  // Reads of the timing register return the value held before the read.
  chk_read_timing: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_rd_hit(sel[0]) |=> REG_RDATA == $past(st_r.dither))
    else $error("timing read back wrong");

  // The page field steers accesses to the configuration or a colour table.
  chk_page_select: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_wr_hit(sel[1]) |=> PAGE_SEL == $past(REG_WDATA[7:6]))
    else $error("page select wrong");

  // Correction is applied only while its enable is one.
  chk_balance_enable: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_wr_hit(sel[1]) |=> BALANCE_ON == $past(REG_WDATA[5]))
    else $error("balance enable wrong");

  // Table reloading is permitted only while its enable is one.
  chk_table_refresh: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_wr_hit(sel[1]) |=> TABLE_REFRESH_ON == $past(REG_WDATA[4]))
    else $error("table refresh enable wrong");

  // An underrun seen after the synchroniser is always recorded.
  chk_underrun_sticky: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    sy.underrun_ev |=> st_r.underrun) else $error("underrun not recorded");

  // A recorded overrun survives until software clears it.
  chk_overrun_holds: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !clr_wr && st_r.overrun |=> st_r.overrun) else $error("overrun lost");

  // The clear bit acts once and is never stored.
  chk_clear_unstored: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_wr_hit(sel[2]) |=> !st_r.audio[`VRXCR_ERR_CLEAR_BIT])
    else $error("clear bit stored");

  // The strobe edge follows bit 0 of the audio register.
  chk_strobe_edge: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_wr_hit(sel[2]) |=> AUDIO_RISING_STROBE == $past(REG_WDATA[0]))
    else $error("strobe edge wrong");

  // Status reads keep reserved bits and the clear bit at zero.
  chk_read_status: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_rd_hit(sel[2]) |=> (REG_RDATA[7:4] == 4'h0) && !REG_RDATA[1])
    else $error("status read reserved bits set");

  // Mode zero with video present gives lock one cycle later.
  chk_video_lock: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_video_link ##0 !st_r.rxport[`VRXCR_LOCK_MODE_BIT] |=> RX_LOCK)
    else $error("lock missing with video");

  // Mode zero with video off never locks, even with the link up.
  chk_bare_no_lock: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_bare_link ##0 !st_r.rxport[`VRXCR_LOCK_MODE_BIT] |=> !RX_LOCK)
    else $error("lock without video in mode zero");

  // No link means no lock in either mode.
  chk_no_link_no_lock: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !sy.linked |=> !RX_LOCK) else $error("lock without link");

  // In raw mode the local pin level passes through unchanged.
  chk_raw_follows: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    RAW_AUX_RETURN_PATH |-> RAW_AUX_DATA == sy.gp_pin) else $error("raw path drops pin");

  // The input mode field follows bits 4 and 3.
  chk_input_mode: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_wr_hit(sel[4]) |=> LINK_INPUT_CONFIG == $past(REG_WDATA[4:3]))
    else $error("input mode wrong");

  // Second-port writes follow bit 1.
  chk_second_write: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_wr_hit(sel[4]) |=> SECOND_PORT_WRITE == $past(REG_WDATA[1]))
    else $error("second port write select wrong");

  // Reads steer to the second port whenever bit 1 is set, whatever bit 0 says.
  chk_second_read: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_wr_hit(sel[4]) |=> SECOND_PORT_READ == $past(REG_WDATA[1]))
    else $error("second port read select wrong");

  // First-port writes follow bit 0.
  chk_first_write: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_wr_hit(sel[4]) |=> FIRST_PORT_WRITE == $past(REG_WDATA[0]))
    else $error("first port write select wrong");

  // Port register reads keep reserved bits at zero.
  chk_read_rxport: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_rd_hit(sel[4]) |=> !REG_RDATA[7] && !REG_RDATA[2])
    else $error("port read reserved bits set");

  // Unmapped offsets read as zero.
  chk_read_unmapped: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    seq_rd_hit(sel == 5'h00) |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
endmodule

// file: tb/tb_vrxcr_regs.sv
`timescale 1ns/1ps
`include "vrxcr_map.svh"
// Self-checking bench for the receiver control register bank.
module tb_vrxcr_regs
  import vrxcr_pkg::*;
;
  // Design inputs.
  logic          CORE_CLK, RESETN, REG_WR, REG_RD;
  vrxcr_byte_t   REG_ADDR, REG_WDATA;
  logic          VIDEO_OFF_PIN, LINKED_PIN, GP_PIN_ZERO, AUDIO_OVERRUN, AUDIO_UNDERRUN;
  // Design outputs.
  logic [7:0]    REG_RDATA;
  logic          REG_HIT, SYNC_FRAMING, LINE_SYNC_POLARITY, FRAME_SYNC_POLARITY;
  logic          VALID_PIXEL_POLARITY, DITHER_STAGE2_ON, DITHER_STAGE1_ON;
  logic          PRECISE_DITHER2_ON, PRECISE_DITHER1_ON, BALANCE_ON, TABLE_REFRESH_ON;
  logic          AUDIO_RISING_STROBE, SELFTEST_CLOCK_SEL, RX_LOCK, RAW_AUX_RETURN_PATH;
  logic          RAW_AUX_DATA, FIRST_PORT_WRITE, SECOND_PORT_WRITE, SECOND_PORT_READ;
  vrxcr_page_e   PAGE_SEL;
  vrxcr_inmode_e LINK_INPUT_CONFIG;
  // Bench state.
  int            mismatches;
  int            total_checks;
  logic [7:0]    dith;
  logic [7:0]    ports;

  // Dither outputs packed in register bit order, precise-dither enables inverted back.
  assign dith = {SYNC_FRAMING, LINE_SYNC_POLARITY, FRAME_SYNC_POLARITY, VALID_PIXEL_POLARITY,
                 DITHER_STAGE2_ON, DITHER_STAGE1_ON, !PRECISE_DITHER2_ON, !PRECISE_DITHER1_ON};
  assign ports = {5'h00, FIRST_PORT_WRITE, SECOND_PORT_WRITE, SECOND_PORT_READ};

  vrxcr_regs uut (
    .CORE_CLK, .RESETN, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA, .REG_HIT,
    .VIDEO_OFF_PIN, .LINKED_PIN, .GP_PIN_ZERO, .AUDIO_OVERRUN, .AUDIO_UNDERRUN,
    .SYNC_FRAMING, .LINE_SYNC_POLARITY, .FRAME_SYNC_POLARITY, .VALID_PIXEL_POLARITY,
    .DITHER_STAGE2_ON, .DITHER_STAGE1_ON, .PRECISE_DITHER2_ON, .PRECISE_DITHER1_ON,
    .PAGE_SEL, .BALANCE_ON, .TABLE_REFRESH_ON, .AUDIO_RISING_STROBE, .SELFTEST_CLOCK_SEL,
    .RX_LOCK, .RAW_AUX_RETURN_PATH, .RAW_AUX_DATA, .LINK_INPUT_CONFIG,
    .FIRST_PORT_WRITE, .SECOND_PORT_WRITE, .SECOND_PORT_READ
  );

  // A 25 ns clock.
  always #12.5 CORE_CLK = ~CORE_CLK;

  // Compares two bytes; case inequality keeps unknowns from passing.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t ns: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask

  // One register write; outputs are settled one cycle later.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
    #1;
  endtask

  // One register read, compared in the cycle after the taking edge.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CORE_CLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1;
    chk(REG_RDATA, exp);
  endtask

  // Sets the status pins, then allows the two sync stages and the lock flop to settle.
  task automatic pins(input logic lk, input logic vo, input logic gp);
    @(posedge CORE_CLK);
    LINKED_PIN    <= lk;
    VIDEO_OFF_PIN <= vo;
    GP_PIN_ZERO   <= gp;
    repeat (4) @(posedge CORE_CLK);
    #1;
  endtask

  // Pulses one audio error pin for a single cycle.
  task automatic pulse(input logic over);
    @(posedge CORE_CLK);
    AUDIO_OVERRUN  <= over;
    AUDIO_UNDERRUN <= !over;
    @(posedge CORE_CLK);
    AUDIO_OVERRUN  <= 1'b0;
    AUDIO_UNDERRUN <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task final_report;
    $display("Checks made: %0d, mismatches: %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog: a hung run counts as a mismatch.
  initial
  begin
    repeat (20000) @(posedge CORE_CLK);
    mismatches++;
    $display("Error at %0t ns: run did not finish", $time);
    final_report;
  end

  // Main sequence.
  initial
  begin
    CORE_CLK = 1'b0;
    RESETN = 1'b0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    VIDEO_OFF_PIN = 1'b1;
    LINKED_PIN = 1'b0;
    GP_PIN_ZERO = 1'b0;
    AUDIO_OVERRUN = 1'b0;
    AUDIO_UNDERRUN = 1'b0;
    repeat (20) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    // Reset values, reset decodes and an unmapped address.
    rd(`VRXCR_DITHER_TIMING_OFS, 8'h00);
    chk(dith, 8'h00);
    rd(`VRXCR_COLOR_BAL_OFS, 8'h00);
    rd(`VRXCR_AUDIO_SER_OFS, 8'h00);
    rd(`VRXCR_PCLK_TEST_OFS, 8'h00);
    rd(`VRXCR_RX_PORT_OFS, 8'h01);
    chk(ports, 8'h04);
    rd(8'h30, 8'h00);
    chk({7'h00, REG_HIT}, 8'h00);
    $display("Test reset finished");
    // Each timing and dither bit alone, decoded and read back.
    for (int i = 0; i < 8; i++)
    begin
      wr(`VRXCR_DITHER_TIMING_OFS, 8'h01 << i);
      chk(dith, 8'h01 << i);
      rd(`VRXCR_DITHER_TIMING_OFS, 8'h01 << i);
    end
    $display("Test dither finished");
    // Every page with both enables, reserved bits dropped, then all off.
    for (int p = 0; p < 4; p++)
    begin
      wr(`VRXCR_COLOR_BAL_OFS, {p[1:0], 6'h3F});
      chk({4'h0, PAGE_SEL, BALANCE_ON, TABLE_REFRESH_ON}, {4'h0, p[1:0], 2'h3});
      rd(`VRXCR_COLOR_BAL_OFS, {p[1:0], 6'h30});
    end
    wr(`VRXCR_COLOR_BAL_OFS, 8'h0F);
    chk({6'h00, BALANCE_ON, TABLE_REFRESH_ON}, 8'h00);
    $display("Test balance finished");
    // Strobe edge, sticky error flags, write-one clear.
    wr(`VRXCR_AUDIO_SER_OFS, 8'hF1);
    chk({7'h00, AUDIO_RISING_STROBE}, 8'h01);
    rd(`VRXCR_AUDIO_SER_OFS, 8'h01);
    wr(`VRXCR_AUDIO_SER_OFS, 8'h00);
    chk({7'h00, AUDIO_RISING_STROBE}, 8'h00);
    pulse(1'b1);
    rd(`VRXCR_AUDIO_SER_OFS, 8'h08);
    pulse(1'b0);
    rd(`VRXCR_AUDIO_SER_OFS, 8'h0C);
    wr(`VRXCR_AUDIO_SER_OFS, 8'h0E);
    rd(`VRXCR_AUDIO_SER_OFS, 8'h00);
    $display("Test audio finished");
    // Pixel clock source select with reserved bits.
    wr(`VRXCR_PCLK_TEST_OFS, 8'hFF);
    chk({7'h00, SELFTEST_CLOCK_SEL}, 8'h01);
    rd(`VRXCR_PCLK_TEST_OFS, 8'h80);
    $display("Test clock finished");
    // Lock in both modes: mode zero with and without video, lock mode with and without link.
    wr(`VRXCR_RX_PORT_OFS, 8'h00);
    pins(1'b1, 1'b1, 1'b0);
    chk({7'h00, RX_LOCK}, 8'h00);
    pins(1'b1, 1'b0, 1'b0);
    chk({7'h00, RX_LOCK}, 8'h01);
    pins(1'b1, 1'b1, 1'b0);
    chk({7'h00, RX_LOCK}, 8'h00);
    wr(`VRXCR_RX_PORT_OFS, 8'h40);
    pins(1'b1, 1'b1, 1'b0);
    chk({7'h00, RX_LOCK}, 8'h01);
    pins(1'b0, 1'b1, 1'b0);
    chk({7'h00, RX_LOCK}, 8'h00);
    $display("Test lock finished");
    // Raw return path follows the local pin only when enabled.
    pins(1'b0, 1'b1, 1'b1);
    chk({6'h00, RAW_AUX_RETURN_PATH, RAW_AUX_DATA}, 8'h00);
    wr(`VRXCR_RX_PORT_OFS, 8'h20);
    pins(1'b0, 1'b1, 1'b1);
    chk({6'h00, RAW_AUX_RETURN_PATH, RAW_AUX_DATA}, 8'h03);
    pins(1'b0, 1'b1, 1'b0);
    chk({6'h00, RAW_AUX_RETURN_PATH, RAW_AUX_DATA}, 8'h02);
    $display("Test raw path finished");
    // Every input link mode.
    for (int m = 0; m < 4; m++)
    begin
      wr(`VRXCR_RX_PORT_OFS, {3'h0, m[1:0], 3'h1});
      chk({6'h00, LINK_INPUT_CONFIG}, {6'h00, m[1:0]});
      rd(`VRXCR_RX_PORT_OFS, {3'h0, m[1:0], 3'h1});
    end
    $display("Test link mode finished");
    // Port routing: second only, both, and all bits written.
    wr(`VRXCR_RX_PORT_OFS, 8'h02);
    chk(ports, 8'h03);
    wr(`VRXCR_RX_PORT_OFS, 8'h03);
    chk(ports, 8'h07);
    wr(`VRXCR_RX_PORT_OFS, 8'h01);
    chk(ports, 8'h04);
    wr(`VRXCR_RX_PORT_OFS, 8'hFF);
    rd(`VRXCR_RX_PORT_OFS, 8'h7B);
    chk({7'h00, REG_HIT}, 8'h01);
    $display("Test port routing finished");
    final_report;
  end
endmodule
